/* File: common/twb_defines.svh */
/*
 * constants of the serial to 2-wire command bridge: command codes, reply
 * codes, reset values, fifo shape and bus bit timing.
 * assumes a 10 MHz ref_clk and a host that sends whole 2-byte commands.
 */
// How it works
// - per-action mode and self-sequencing packet mode
// - single commands: start, stop, write, read
// - each single command replies its code plus 0x10, or 0xFA
// - packet commands only from revision 2.0
// - set-address command stores packet target address
// - target address kept until next set-address
// - set-address replies 0xB5, or 0xFA
// - device sets read/write bit itself
// - 0x8n packet write, n+1 data bytes
// - whole payload buffered before bus starts
// - start, address, memory address, data, stop
// - every byte acked echoes command, else 0xFA
// - 0x9n packet read, n+1 bytes
// - second read byte is start memory address
// - read begins with dummy write of address
// - repeated start then address with read bit
// - ack all read bytes but last; forward each
// - after data send command byte or 0xFA
// - single read returns data then 0xB2
`ifndef TWB_DEFINES_SVH
`define TWB_DEFINES_SVH

// ======================================================================
// command and reply codes
`define TWB_CODE_ERR      8'hFA
`define TWB_CMD_START     8'hA0
`define TWB_CMD_WRITE     8'hA1
`define TWB_CMD_READ      8'hA2
`define TWB_CMD_STOP      8'hA3
`define TWB_CMD_TOGGLE    8'hA4
`define TWB_CMD_SETADR    8'hA5
`define TWB_NIB_SINGLE    4'hA
`define TWB_NIB_PWRITE    4'h8
`define TWB_NIB_PREAD     4'h9
`define TWB_ACK_OFS       8'h10
`define TWB_RW_BIT        0

// ======================================================================
// revisions
`define TWB_REV_MAJOR     2
`define TWB_PKT_REV       2

// ======================================================================
// reset values and sizes
`define TWB_ADDR_RST      8'h00
`define TWB_FIFO_W        8
`define TWB_FIFO_D        16
`define TWB_TICK_W        8

// ======================================================================
// bus timing: quarter of a 10 us bit, rounded up to whole clocks
`define TWB_CLK_NS        100
`define TWB_QTR_NS        2500
`define TWB_QTR_CYC ((`TWB_QTR_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`define TWB_BYTE_LAST     6'h23
`define TWB_START_LAST    6'h03
`define TWB_STOP_LAST     6'h02

`endif

/* File: common/twb_pkg.sv */
/*
 * types of the serial to 2-wire command bridge.
 * assumes twb_defines.svh supplies the widths.
 */
`include "twb_defines.svh"

package twb_pkg;

   // =====================================================================
   // command sequencer states
   typedef enum logic [4:0] {
      ST_IDLE, ST_ARG, ST_PW_FILL, ST_START, ST_ADDR_W, ST_MEM, ST_PW_BYTE,
      ST_FLUSH, ST_RSTART, ST_ADDR_R, ST_PR_BYTE, ST_PR_SEND, ST_STOP,
      ST_IND, ST_RDATA, ST_REPLY
   } twb_st_t;

   // =====================================================================
   // bus engine operations
   typedef enum logic [2:0] {
      E_IDLE, E_START, E_STOP, E_WRITE, E_READ
   } twb_eop_t;

   // =====================================================================
   // whole state of the bridge
   typedef struct packed {
      twb_st_t                 st;
      logic [7:0]              cmd;
      logic [7:0]              arg;
      logic [7:0]              addr;
      logic [4:0]              cnt;
      logic                    err;
      logic                    launched;
      logic                    rx_ready;
      logic                    tx_valid;
      logic [7:0]              tx_data;
      twb_eop_t                e_op;
      logic [5:0]              e_step;
      logic [`TWB_TICK_W-1:0]  e_tick;
      logic [7:0]              e_sh;
      logic                    e_ack;
      logic                    e_nack;
      logic                    e_done;
      logic                    scl_oe;
      logic                    sda_oe;
      logic                    scl_m;
      logic                    scl_s;
      logic                    sda_m;
      logic                    sda_s;
   } twb_state_t;

endpackage : twb_pkg

/* File: design/twb_bridge.sv */
/*
 * serial byte command interpreter driving a 2-wire bus as master.
 * assumes a host byte stream with valid/ready on the same clock and
 * open-drain scl/sda pins with external pullups.
 */
`timescale 1ns/1ps
`include "twb_defines.svh"

module twb_bridge #(
   parameter int REV_MAJOR = `TWB_REV_MAJOR,
   parameter int QTR_CYC   = `TWB_QTR_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // host command bytes in
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   // reply bytes out
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // 2-wire clock pin
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   // 2-wire data pin
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);

   localparam logic PKT_EN = (REV_MAJOR >= `TWB_PKT_REV);
   localparam logic [`TWB_TICK_W-1:0] TICK_END =
      `TWB_TICK_W'(QTR_CYC - 1);

   twb_pkg::twb_state_t  s_ff;
   twb_pkg::twb_state_t  nxt_s;
   logic                 fifo_push;
   logic                 fifo_pop;
   logic                 fifo_in_ready;
   logic                 fifo_out_valid;
   logic [7:0]           fifo_out_data;

   // ====================================================================
   // pin drive levels per step: {scl low, sda low}
   function automatic logic [1:0] lv(twb_pkg::twb_eop_t op,
                                     logic [5:0] st, logic [7:0] sh,
                                     logic ack, logic scl_now);
      logic [3:0] b;
      logic [1:0] ph;
      logic       clk_low;
      logic [1:0] r;
      b       = st[5:2];
      ph      = st[1:0];
      clk_low = (ph == 2'd0) || (ph == 2'd3);
      r       = 2'b00;
      case (op)
         twb_pkg::E_START: begin
            case (ph)
               2'd0:    r = {scl_now, 1'b0};
               2'd1:    r = 2'b00;
               2'd2:    r = 2'b01;
               default: r = 2'b11;
            endcase
         end
         twb_pkg::E_STOP: begin
            case (ph)
               2'd0:    r = {scl_now, 1'b1};
               2'd1:    r = 2'b01;
               default: r = 2'b00;
            endcase
         end
         twb_pkg::E_WRITE: begin
            r = {clk_low, (b < 4'd8) ? ~sh[3'(4'd7 - b)] : 1'b0};
         end
         twb_pkg::E_READ: begin
            r = {clk_low, (b == 4'd8) ? ack : 1'b0};
         end
         default: r = 2'b00;
      endcase
      return r;
   endfunction : lv

   function automatic logic [5:0] last_step(twb_pkg::twb_eop_t op);
      case (op)
         twb_pkg::E_START: return `TWB_START_LAST;
         twb_pkg::E_STOP:  return `TWB_STOP_LAST;
         default:          return `TWB_BYTE_LAST;
      endcase
   endfunction : last_step

   // ====================================================================
   // hand one operation to the bus engine
   function automatic twb_pkg::twb_state_t launch(
         twb_pkg::twb_state_t x, twb_pkg::twb_eop_t op,
         logic [7:0] sh, logic ack);
      twb_pkg::twb_state_t y;
      y          = x;
      y.launched = 1'b1;
      y.e_op     = op;
      y.e_step   = '0;
      y.e_tick   = '0;
      y.e_sh     = sh;
      y.e_ack    = ack;
      y.e_nack   = 1'b0;
      {y.scl_oe, y.sda_oe} = lv(op, 6'h00, sh, ack, x.scl_oe);
      return y;
   endfunction : launch

   // ====================================================================
   // reply code of the current command
   function automatic logic [7:0] reply(logic [7:0] cmd, logic err);
      if (err) begin
         return `TWB_CODE_ERR;
      end else if (cmd[7:4] == `TWB_NIB_SINGLE) begin
         return cmd + `TWB_ACK_OFS;
      end
      return cmd;
   endfunction : reply

   // ====================================================================
   // next state
   always_comb begin
      nxt_s        = s_ff;
      fifo_pop     = 1'b0;
      fifo_push    = 1'b0;
      nxt_s.e_done = 1'b0;
      // pins cross into this clock through two flops
      nxt_s.scl_m  = scl_in;
      nxt_s.scl_s  = s_ff.scl_m;
      nxt_s.sda_m  = sda_in;
      nxt_s.sda_s  = s_ff.sda_m;

      // bus engine; a held-low scl stretches the step
      if (s_ff.e_op != twb_pkg::E_IDLE && (s_ff.scl_oe || s_ff.scl_s))
      begin
         if (s_ff.e_tick == TICK_END) begin
            nxt_s.e_tick = '0;
            if (s_ff.e_step[1:0] == 2'd2) begin
               if (s_ff.e_op == twb_pkg::E_WRITE &&
                   s_ff.e_step[5:2] == 4'd8) begin
                  nxt_s.e_nack = s_ff.sda_s;
               end else if (s_ff.e_op == twb_pkg::E_READ &&
                            s_ff.e_step[5:2] < 4'd8) begin
                  nxt_s.e_sh = {s_ff.e_sh[6:0], s_ff.sda_s};
               end
            end
            if (s_ff.e_step == last_step(s_ff.e_op)) begin
               nxt_s.e_op   = twb_pkg::E_IDLE;
               nxt_s.e_done = 1'b1;
            end else begin
               nxt_s.e_step = s_ff.e_step + 6'h01;
               {nxt_s.scl_oe, nxt_s.sda_oe} =
                  lv(s_ff.e_op, s_ff.e_step + 6'h01, s_ff.e_sh,
                     s_ff.e_ack, s_ff.scl_oe);
            end
         end else begin
            nxt_s.e_tick = s_ff.e_tick + 1'b1;
         end
      end

      // command sequencer, one command at a time
      case (s_ff.st)
         twb_pkg::ST_IDLE: begin
            if (rx_valid && s_ff.rx_ready) begin
               nxt_s.cmd = rx_data;
               nxt_s.err = 1'b0;
               nxt_s.st  = twb_pkg::ST_ARG;
            end
         end
         twb_pkg::ST_ARG: begin
            if (rx_valid && s_ff.rx_ready) begin
               nxt_s.arg = rx_data;
               nxt_s.cnt = {1'b0, s_ff.cmd[3:0]} + 5'h01;
               if (PKT_EN && s_ff.cmd[7:4] == `TWB_NIB_PWRITE) begin
                  nxt_s.st = twb_pkg::ST_PW_FILL;
               end else if (PKT_EN &&
                            s_ff.cmd[7:4] == `TWB_NIB_PREAD) begin
                  nxt_s.st = twb_pkg::ST_START;
               end else if (PKT_EN && s_ff.cmd == `TWB_CMD_SETADR) begin
                  nxt_s.addr = rx_data;
                  nxt_s.st   = twb_pkg::ST_REPLY;
               end else if (s_ff.cmd >= `TWB_CMD_START &&
                            s_ff.cmd <= `TWB_CMD_TOGGLE) begin
                  nxt_s.st = twb_pkg::ST_IND;
               end else begin
                  nxt_s.err = 1'b1;
                  nxt_s.st  = twb_pkg::ST_REPLY;
               end
            end
         end
         twb_pkg::ST_PW_FILL: begin
            if (rx_valid && s_ff.rx_ready && fifo_in_ready) begin
               fifo_push = 1'b1;
               nxt_s.cnt = s_ff.cnt - 5'h01;
               if (s_ff.cnt == 5'h01) begin
                  nxt_s.st = twb_pkg::ST_START;
               end
            end
         end
         twb_pkg::ST_START, twb_pkg::ST_RSTART: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_START, 8'h00, 1'b0);
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               nxt_s.st = (s_ff.st == twb_pkg::ST_START) ?
                          twb_pkg::ST_ADDR_W : twb_pkg::ST_ADDR_R;
            end
         end
         twb_pkg::ST_ADDR_W: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_WRITE,
                              {s_ff.addr[7:1], 1'b0}, 1'b0);
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               if (nxt_s.e_nack) begin
                  nxt_s.err = 1'b1;
                  nxt_s.st  = s_ff.cmd[4] ? twb_pkg::ST_STOP
                                          : twb_pkg::ST_FLUSH;
               end else begin
                  nxt_s.st = twb_pkg::ST_MEM;
               end
            end
         end
         twb_pkg::ST_MEM: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_WRITE,
                              s_ff.arg, 1'b0);
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               if (nxt_s.e_nack) begin
                  nxt_s.err = 1'b1;
                  nxt_s.st  = s_ff.cmd[4] ? twb_pkg::ST_STOP
                                          : twb_pkg::ST_FLUSH;
               end else begin
                  nxt_s.st  = s_ff.cmd[4] ? twb_pkg::ST_RSTART
                                          : twb_pkg::ST_PW_BYTE;
               end
            end
         end
         twb_pkg::ST_PW_BYTE: begin
            if (!s_ff.launched) begin
               if (fifo_out_valid) begin
                  fifo_pop = 1'b1;
                  nxt_s = launch(nxt_s, twb_pkg::E_WRITE,
                                 fifo_out_data, 1'b0);
               end else begin
                  nxt_s.st = twb_pkg::ST_STOP;
               end
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               if (nxt_s.e_nack) begin
                  nxt_s.err = 1'b1;
                  nxt_s.st  = twb_pkg::ST_FLUSH;
               end
            end
         end
         twb_pkg::ST_FLUSH: begin
            // leftover payload must go, or the next packet would see it
            if (fifo_out_valid) begin
               fifo_pop = 1'b1;
            end else begin
               nxt_s.st = twb_pkg::ST_STOP;
            end
         end
         twb_pkg::ST_ADDR_R: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_WRITE,
                              {s_ff.addr[7:1], 1'b1}, 1'b0);
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               nxt_s.err = nxt_s.e_nack;
               nxt_s.st  = nxt_s.e_nack ? twb_pkg::ST_STOP
                                        : twb_pkg::ST_PR_BYTE;
            end
         end
         twb_pkg::ST_PR_BYTE: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_READ, 8'h00,
                              (s_ff.cnt != 5'h01));
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               nxt_s.cnt = s_ff.cnt - 5'h01;
               nxt_s.st  = twb_pkg::ST_PR_SEND;
            end
         end
         twb_pkg::ST_STOP: begin
            if (!s_ff.launched) begin
               nxt_s = launch(nxt_s, twb_pkg::E_STOP, 8'h00, 1'b0);
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               nxt_s.st = twb_pkg::ST_REPLY;
            end
         end
         twb_pkg::ST_IND: begin
            if (!s_ff.launched) begin
               case (s_ff.cmd)
                  `TWB_CMD_START:
                     nxt_s = launch(nxt_s, twb_pkg::E_START, 8'h00, 1'b0);
                  `TWB_CMD_WRITE:
                     nxt_s = launch(nxt_s, twb_pkg::E_WRITE, s_ff.arg, 1'b0);
                  `TWB_CMD_READ:
                     nxt_s = launch(nxt_s, twb_pkg::E_READ, 8'h00,
                                    s_ff.arg[0]);
                  `TWB_CMD_STOP:
                     nxt_s = launch(nxt_s, twb_pkg::E_STOP, 8'h00, 1'b0);
                  // nine released clocks end in a nack
                  default:
                     nxt_s = launch(nxt_s, twb_pkg::E_READ, 8'h00, 1'b0);
               endcase
            end else if (s_ff.e_done) begin
               nxt_s.launched = 1'b0;
               nxt_s.err = (s_ff.cmd == `TWB_CMD_WRITE) && nxt_s.e_nack;
               nxt_s.st  = (s_ff.cmd == `TWB_CMD_READ) ? twb_pkg::ST_RDATA
                                                       : twb_pkg::ST_REPLY;
            end
         end
         twb_pkg::ST_PR_SEND, twb_pkg::ST_RDATA, twb_pkg::ST_REPLY: begin
            if (!s_ff.tx_valid) begin
               nxt_s.tx_valid = 1'b1;
               nxt_s.tx_data  = (s_ff.st == twb_pkg::ST_REPLY) ?
                                reply(s_ff.cmd, s_ff.err)
                                : s_ff.e_sh;
            end else if (tx_ready) begin
               nxt_s.tx_valid = 1'b0;
               case (s_ff.st)
                  twb_pkg::ST_PR_SEND:
                     nxt_s.st = (s_ff.cnt == 5'h00) ? twb_pkg::ST_STOP
                                                    : twb_pkg::ST_PR_BYTE;
                  twb_pkg::ST_RDATA:
                     nxt_s.st = twb_pkg::ST_REPLY;
                  default:
                     nxt_s.st = twb_pkg::ST_IDLE;
               endcase
            end
         end
         default: nxt_s.st = twb_pkg::ST_IDLE;
      endcase

      // take bytes only while a command is being gathered
      case (nxt_s.st)
         twb_pkg::ST_IDLE, twb_pkg::ST_ARG: nxt_s.rx_ready = 1'b1;
         twb_pkg::ST_PW_FILL:
            nxt_s.rx_ready = fifo_in_ready && !(fifo_push &&
                             s_ff.cnt == 5'h01);
         default: nxt_s.rx_ready = 1'b0;
      endcase
   end

   // ====================================================================
   // state register; packet address kept across commands
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ====================================================================
   // packet write payload buffer
   twb_fifo #(
      .W (`TWB_FIFO_W),
      .D (`TWB_FIFO_D)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (fifo_push),
      .in_data   (rx_data),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_pop)
   );

   // ====================================================================
   // outputs; open-drain pins only ever pull low
   assign rx_ready = s_ff.rx_ready;
   assign tx_valid = s_ff.tx_valid;
   assign tx_data  = s_ff.tx_data;
   assign scl_oe   = s_ff.scl_oe;
   assign sda_oe   = s_ff.sda_oe;
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;

endmodule : twb_bridge

/* File: design/twb_fifo.sv */
/*
 * payload fifo with valid/ready on both sides.
 * assumes one clock; the reader may stall, so it really fills.
 */
`timescale 1ns/1ps
`include "twb_defines.svh"

module twb_fifo #(
   parameter int W = `TWB_FIFO_W,
   parameter int D = `TWB_FIFO_D
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   num;
   } twb_fifo_st_t;

   twb_fifo_st_t  s_ff;
   twb_fifo_st_t  nxt_s;
   logic [W-1:0]  mem [D];
   logic          push;
   logic          pop;

   // ====================================================================
   // flags and next state
   assign in_ready  = (s_ff.num != (AW+1)'(D));
   assign out_valid = (s_ff.num != '0);
   assign out_data  = mem[s_ff.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_s = s_ff;
      if (push) begin
         nxt_s.wp = (s_ff.wp == AW'(D-1)) ? '0 : s_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_s.rp = (s_ff.rp == AW'(D-1)) ? '0 : s_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_s.num = s_ff.num + 1'b1;
      end else if (pop && !push) begin
         nxt_s.num = s_ff.num - 1'b1;
      end
   end

   // ====================================================================
   // registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[s_ff.wp] <= in_data;
      end
   end

endmodule : twb_fifo

/* File: sim/tb_top.sv */
/* bench: host tasks drive the bridge, a target model answers.
   assumes bridge, fifo, model and checker compiled first. */
`timescale 1ns/1ps

module tb_top;
   // ========
   // signals
   logic       ref_clk = 1'b0;
   logic       nrst = 1'b0;
   logic       rx_valid = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic       tx_ready = 1'b0;
   logic       rx_ready, tx_valid, scl_oe, sda_oe, t_oe;
   logic [7:0] tx_data;
   wire        scl = !scl_oe;
   wire        sda = !(sda_oe || t_oe);
   int         bad_count = 0;
   int         check_count = 0;
   int         acts = 0;
   always #50 ref_clk = !ref_clk;
   always @(posedge scl_oe) acts++;
   twb_bridge #(.QTR_CYC(2)) uut (.ref_clk(ref_clk), .nrst(nrst),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
   twb_target_model #(.DEV(8'hA0)) u_tgt (.scl(scl), .sda(sda), .sda_oe(t_oe));
   // ========
   // host tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d bad %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic lim(input int n);
      if (n >= 9000) begin
         bad_count++;
         finish_test();
      end
   endtask : lim
   task automatic put(input logic [7:0] b);
      int n = 0;
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      do @(posedge ref_clk); while (rx_ready !== 1'b1 && ++n < 9000);
      rx_valid <= 1'b0;
      lim(n);
   endtask : put
   task automatic get(input logic [7:0] exp);
      int n = 0;
      @(posedge ref_clk);
      tx_ready <= 1'b1;
      do @(posedge ref_clk); while (tx_valid !== 1'b1 && ++n < 9000);
      tx_ready <= 1'b0;
      lim(n);
      chk(tx_data, exp);
   endtask : get
   task automatic cmd(input logic [23:0] s);
      put(s[23:16]);
      put(s[15:8]);
      get(s[7:0]);
   endtask : cmd
   // ========
   // scenarios
   task automatic t_single;
      logic [23:0] s [9] = '{24'hA000B0, 24'hA1A0B1, 24'hA105B1, 24'hA000B0,
         24'hA1A1B1, 24'hA200FA, 24'hA3FFB3, 24'hA400B4, 24'h5500FA};
      int a0 = 0;
      foreach (s[i]) begin
         if (i == 8) a0 = acts;
         cmd(s[i]);
         if (i == 5) get(8'hB2);
      end
      chk(8'(acts - a0), 8'h00);
      $display("single commands done");
   endtask : t_single
   task automatic t_packet(input logic [3:0] n, input logic [7:0] ma, dev);
      int a0 = 0;
      cmd({8'hA5, dev, 8'hB5});
      put({4'h8, n});
      put(ma);
      a0 = acts;
      for (int i = 0; i <= n; i++) begin
         if (i == n) repeat (40) @(posedge ref_clk);
         if (i == n) chk(8'(acts - a0), 8'h00);
         put(ma + 8'(i) + 8'h3);
      end
      get({4'h8, n});
      put({4'h9, n});
      put(ma);
      for (int i = 0; i <= n; i++) get(ma + 8'(i) + 8'h3);
      get({4'h9, n});
      $display("packet of %0d done", n + 1);
   endtask : t_packet
   task automatic t_error;
      cmd(24'hA5B0B5);
      put(8'h80);
      put(8'h00);
      put(8'h11);
      get(8'hFA);
      cmd(24'h9000FA);
      $display("nack cases done");
   endtask : t_error
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      t_single();
      t_packet(4'h2, 8'h20, 8'hA0);
      t_packet(4'hF, 8'h30, 8'hA0);
      t_error();
      finish_test();
   end
endmodule : tb_top

/* File: sim/twb_bridge_properties.sv */
/* port assertions of the command bridge.
   assumes a bind into twb_bridge and one clock. */
`timescale 1ns/1ps

module twb_bridge_properties (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       nrst,
   // host bytes
   input wire logic       rx_valid,
   input wire logic       rx_ready,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   // pins
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   // ========
   // silent cycles; a hung sequencer shows here
   logic [12:0] wait_ff;
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst) wait_ff <= 13'h0;
      else wait_ff <= (rx_ready || tx_valid) ? 13'h0 : wait_ff + 13'h1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ========
   // assertions
   a_tx_hold: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable(tx_data)) else $error("reply byte lost");
   a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("reply repeated");
   a_one_cmd: assert property (tx_valid |-> !rx_ready)
      else $error("byte taken during reply");
   a_ready_drop: assert property ($fell(rx_ready)
      |-> $past(rx_valid) || $past(rx_valid, 2)) else $error("ready fell");
   a_ready_back: assert property ($rose(rx_ready)
      |-> !$past(nrst, 2) || $past(tx_valid) && $past(tx_ready))
      else $error("ready before reply taken");
   a_scl_quarter: assert property ($rose(scl_oe) |=> scl_oe)
      else $error("scl low too short");
   a_pins_low: assert property (!scl_out && !sda_out)
      else $error("pin drives high");
   a_sda_settle: assert property ($fell(scl_oe) |-> $stable(sda_oe))
      else $error("sda moved as scl released");
   a_reply_bound: assert property (wait_ff < 13'hFA0)
      else $error("no reply");
   c_pw: cover property (tx_valid && tx_ready && tx_data == 8'h82);
   c_pr: cover property (tx_valid && tx_ready && tx_data == 8'h9F);
   c_err: cover property (tx_valid && tx_ready && tx_data == 8'hFA);
endmodule : twb_bridge_properties

bind twb_bridge twb_bridge_properties u_props (.ref_clk(ref_clk),
   .nrst(nrst), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

/* File: sim/twb_target_model.sv */
/* behavioural 2-wire target with 256 bytes, auto-incrementing.
   assumes open-drain wires resolved by the bench. */
`timescale 1ns/1ps

module twb_target_model #(
   parameter logic [7:0] DEV = 8'hA0
) (
   // wires
   input wire logic scl,
   input wire logic sda,
   // sda pull-down
   output logic     sda_oe = 1'b0
);
   logic [7:0] mem [256];
   logic [7:0] sh, ptr, out;
   logic [3:0] bitc = 4'h0;
   logic       live = 1'b0, first, rd, go, nb;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF - 8'(i);
   // ========
   // framing
   always @(negedge sda) if (scl === 1'b1) begin
      {bitc, first, rd, live} = {4'h0, 3'b101};
   end
   always @(posedge sda) if (scl === 1'b1) live = 1'b0;
   always @(posedge scl) begin
      if (bitc == 4'h8) go = rd && !sda;
      else sh = {sh[6:0], sda};
      bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
   end
   // ========
   // ack and data drive, changed only while scl is low
   always @(negedge scl) begin
      sda_oe = 1'b0;
      if (live && bitc == 4'h8 && !rd) begin
         sda_oe = !first || sh[7:1] == DEV[7:1];
         if (first) rd = sh[0] && sda_oe;
         if (!first && nb) mem[ptr] = sh;
         if (!first) ptr = nb ? ptr + 8'h1 : sh;
         nb = !first;
         first = 1'b0;
      end else if (live && rd && go && bitc < 4'h8) begin
         if (bitc == 4'h0) out = mem[ptr];
         if (bitc == 4'h0) ptr = ptr + 8'h1;
         sda_oe = !out[3'h7 - bitc[2:0]];
      end
   end
endmodule : twb_target_model
